/* File: nvs_access.sv */
// Nonvolatile data EEPROM and program Flash self-access controller
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns

module nvs_access #(
  parameter bit LARGE = 1'b1,
  parameter int WRITE_CYCLES = nvs_pkg::WRITE_CYCLES_DFLT
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic [nvs_pkg::ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_stb_in,
  input wire logic rd_stb_in,
  output logic [7:0] rdata_out,
  input wire logic pin_reset_in,
  input wire logic wdt_reset_in,
  output logic irq_req_out,
  output logic write_busy_out,
  output logic charge_pump_on_out
);

  // Program word index with wrap to the implemented size
  function automatic logic [10:0] fl_index(
    input logic [nvs_pkg::AHI_W-1:0] hi,
    input logic [7:0] lo
  );
    logic [12:0] full;
    full = {hi, lo};
    if (LARGE)
    begin
      fl_index = full[10:0] & nvs_pkg::FL_MASK_LARGE;
    end
    else
    begin
      fl_index = full[10:0] & nvs_pkg::FL_MASK_SMALL;
    end
  endfunction

  // True when a data EEPROM address is backed by storage
  function automatic logic ee_present(input logic [7:0] a);
    ee_present = LARGE || (a <= nvs_pkg::EE_SMALL_TOP);
  endfunction

  logic [7:0] ee_mem [nvs_pkg::EE_DEPTH];
  logic [nvs_pkg::WORD_W-1:0] fl_mem [nvs_pkg::FL_DEPTH];

  nvs_pkg::nvs_state_t state_ff, nxt_state;
  nvs_pkg::nvs_ctl_t ctl_ff, nxt_ctl;
  logic [nvs_pkg::TMR_W-1:0] tmr_ff, nxt_tmr;
  logic flag_ff, nxt_flag;
  logic ien_ff, nxt_ien;
  logic [7:0] dlo_ff, nxt_dlo;
  logic [nvs_pkg::DHI_W-1:0] dhi_ff, nxt_dhi;
  logic [7:0] alo_ff, nxt_alo;
  logic [nvs_pkg::AHI_W-1:0] ahi_ff, nxt_ahi;
  logic [nvs_pkg::BLOCK_WORDS-1:0][nvs_pkg::WORD_W-1:0] blk_ff, nxt_blk;
  logic [7:0] rdata_ff, nxt_rdata;
  logic pump_ff, nxt_pump;
  // Operation captured at its start; a register write under a running write cannot redirect it
  logic op_erase_ff, nxt_op_erase;
  logic op_prog_ff, nxt_op_prog;
  logic [10:0] op_idx_ff, nxt_op_idx;
  logic [7:0] op_alo_ff, nxt_op_alo;
  logic [nvs_pkg::WORD_W-1:0] op_word_ff, nxt_op_word;
  logic [nvs_pkg::WORD_W-1:0] commit_word [nvs_pkg::BLOCK_WORDS];

  logic ee_we;
  logic fl_prog;
  logic fl_erase;
  logic warm_reset;
  logic busy;
  logic [10:0] fl_idx;
  logic [nvs_pkg::WORD_W-1:0] cur_word;
  logic [7:0] ctl_byte;

  assign warm_reset = pin_reset_in | wdt_reset_in;
  assign busy = (state_ff == nvs_pkg::ST_WRITE);
  assign fl_idx = fl_index(ahi_ff, alo_ff);
  assign cur_word = {dhi_ff, dlo_ff};

  always_comb
  begin
    ctl_byte = 8'h00;
    ctl_byte[nvs_pkg::CTL_PGM] = ctl_ff.pgm;
    ctl_byte[nvs_pkg::CTL_FREE] = ctl_ff.free;
    ctl_byte[nvs_pkg::CTL_ERR] = ctl_ff.err;
    ctl_byte[nvs_pkg::CTL_WRITE_PERMIT] = ctl_ff.write_permit;
    ctl_byte[nvs_pkg::CTL_WR] = ctl_ff.wr;
    ctl_byte[nvs_pkg::CTL_RD] = ctl_ff.rd;
  end

  // Read port; unmapped addresses and the unlock port answer zero
  always_comb
  begin
    nxt_rdata = 8'h00;
    if (rd_stb_in)
    begin
      case (addr_in)
        nvs_pkg::OFF_IRQ_FLAGS: nxt_rdata[nvs_pkg::IRQ_BIT] = flag_ff;
        nvs_pkg::OFF_IRQ_EN: nxt_rdata[nvs_pkg::IRQ_BIT] = ien_ff;
        nvs_pkg::OFF_DATA_LO: nxt_rdata = dlo_ff;
        nvs_pkg::OFF_DATA_HI: nxt_rdata = {2'h0, dhi_ff};
        nvs_pkg::OFF_ADDR_LO: nxt_rdata = alo_ff;
        nvs_pkg::OFF_ADDR_HI: nxt_rdata = {3'h0, ahi_ff};
        nvs_pkg::OFF_CTL: nxt_rdata = ctl_byte;
        nvs_pkg::OFF_UNLOCK: nxt_rdata = 8'h00;
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // Read data stands for one cycle only, then drops back to zero
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rdata_ff <= 8'h00;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_ctl = ctl_ff;
    nxt_tmr = tmr_ff;
    nxt_flag = flag_ff;
    nxt_ien = ien_ff;
    nxt_dlo = dlo_ff;
    nxt_dhi = dhi_ff;
    nxt_alo = alo_ff;
    nxt_ahi = ahi_ff;
    nxt_blk = blk_ff;
    // A captured operation holds until the next one starts
    nxt_op_erase = op_erase_ff;
    nxt_op_prog = op_prog_ff;
    nxt_op_idx = op_idx_ff;
    nxt_op_alo = op_alo_ff;
    nxt_op_word = op_word_ff;
    ee_we = 1'b0;
    fl_prog = 1'b0;
    fl_erase = 1'b0;

    // Register writes
    if (wr_stb_in)
    begin
      case (addr_in)
        nvs_pkg::OFF_IRQ_FLAGS: nxt_flag = wdata_in[nvs_pkg::IRQ_BIT];
        nvs_pkg::OFF_IRQ_EN: nxt_ien = wdata_in[nvs_pkg::IRQ_BIT];
        nvs_pkg::OFF_DATA_LO: nxt_dlo = wdata_in;
        nvs_pkg::OFF_DATA_HI: nxt_dhi = wdata_in[nvs_pkg::DHI_W-1:0];
        nvs_pkg::OFF_ADDR_LO: nxt_alo = wdata_in;
        nvs_pkg::OFF_ADDR_HI: nxt_ahi = wdata_in[nvs_pkg::AHI_W-1:0];
        nvs_pkg::OFF_CTL:
        begin
          // Space select must not change under a running write
          if (!busy)
          begin
            nxt_ctl.pgm = wdata_in[nvs_pkg::CTL_PGM];
          end
          nxt_ctl.free = wdata_in[nvs_pkg::CTL_FREE];
          nxt_ctl.err = wdata_in[nvs_pkg::CTL_ERR];
          nxt_ctl.write_permit = wdata_in[nvs_pkg::CTL_WRITE_PERMIT];
          // Triggers only OR in; a zero write never stops an operation
          nxt_ctl.rd = ctl_ff.rd | wdata_in[nvs_pkg::CTL_RD];
          nxt_ctl.wr = ctl_ff.wr | (wdata_in[nvs_pkg::CTL_WR] & ctl_ff.write_permit);
        end
        default: ;
      endcase
    end

    // Access engine; code protection plays no part here
    case (state_ff)
      nvs_pkg::ST_IDLE:
      begin
        if (ctl_ff.rd)
        begin
          if (ctl_ff.pgm)
          begin
            nxt_dlo = fl_mem[fl_idx][7:0];
            nxt_dhi = fl_mem[fl_idx][nvs_pkg::WORD_W-1:8];
          end
          else if (ee_present(alo_ff))
          begin
            nxt_dlo = ee_mem[alo_ff];
          end
          else
          begin
            nxt_dlo = nvs_pkg::BYTE_ZERO;
          end
          nxt_ctl.rd = 1'b0;
        end
        else if (ctl_ff.wr)
        begin
          if (ctl_ff.pgm && !ctl_ff.free && (alo_ff[1:0] != nvs_pkg::LAST_IN_BLOCK))
          begin
            // Early words of a block only land in the holding buffer
            nxt_blk[alo_ff[1:0]] = cur_word;
            nxt_ctl.wr = 1'b0;
          end
          else
          begin
            nxt_state = nvs_pkg::ST_WRITE;
            nxt_tmr = nvs_pkg::TMR_W'(WRITE_CYCLES - 1);
            // Kind, target and data are frozen here for the whole timed write
            nxt_op_erase = ctl_ff.pgm && ctl_ff.free;
            nxt_op_prog = ctl_ff.pgm && !ctl_ff.free;
            nxt_op_idx = fl_idx;
            nxt_op_alo = alo_ff;
            nxt_op_word = cur_word;
          end
        end
      end
      nvs_pkg::ST_WRITE:
      begin
        if (tmr_ff == '0)
        begin
          if (op_erase_ff)
          begin
            fl_erase = 1'b1;
          end
          else if (op_prog_ff)
          begin
            fl_prog = 1'b1;
          end
          else
          begin
            ee_we = ee_present(op_alo_ff);
          end
          nxt_ctl.wr = 1'b0;
          nxt_flag = 1'b1;
          nxt_state = nvs_pkg::ST_IDLE;
        end
        else
        begin
          nxt_tmr = tmr_ff - 1'b1;
        end
      end
      default: nxt_state = nvs_pkg::ST_IDLE;
    endcase

    // Pin or watchdog reset: abort, keep data and address pair
    if (warm_reset)
    begin
      if (busy)
      begin
        nxt_ctl.err = 1'b1;
      end
      nxt_ctl.pgm = 1'b0;
      nxt_ctl.free = 1'b0;
      nxt_ctl.write_permit = 1'b0;
      nxt_ctl.wr = 1'b0;
      nxt_ctl.rd = 1'b0;
      nxt_flag = 1'b0;
      nxt_ien = 1'b0;
      nxt_state = nvs_pkg::ST_IDLE;
      ee_we = 1'b0;
      fl_prog = 1'b0;
      fl_erase = 1'b0;
    end

    // Pump runs only while a real write or erase is timing
    nxt_pump = (nxt_state == nvs_pkg::ST_WRITE) &&
      (nxt_op_erase || nxt_op_prog || ee_present(nxt_op_alo));
  end

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_ff <= nvs_pkg::ST_IDLE;
      ctl_ff <= '0;
      tmr_ff <= '0;
      flag_ff <= 1'b0;
      ien_ff <= 1'b0;
      dlo_ff <= 8'h00;
      dhi_ff <= '0;
      alo_ff <= 8'h00;
      ahi_ff <= '0;
      blk_ff <= '0;
      op_erase_ff <= 1'b0;
      op_prog_ff <= 1'b0;
      op_idx_ff <= '0;
      op_alo_ff <= 8'h00;
      op_word_ff <= '0;
      pump_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      ctl_ff <= nxt_ctl;
      tmr_ff <= nxt_tmr;
      flag_ff <= nxt_flag;
      ien_ff <= nxt_ien;
      dlo_ff <= nxt_dlo;
      dhi_ff <= nxt_dhi;
      alo_ff <= nxt_alo;
      ahi_ff <= nxt_ahi;
      blk_ff <= nxt_blk;
      op_erase_ff <= nxt_op_erase;
      op_prog_ff <= nxt_op_prog;
      op_idx_ff <= nxt_op_idx;
      op_alo_ff <= nxt_op_alo;
      op_word_ff <= nxt_op_word;
      pump_ff <= nxt_pump;
    end
  end

  // Arrays carry no reset: contents survive every reset
  always_ff @(posedge mclk_in)
  begin
    if (ee_we)
    begin
      ee_mem[op_alo_ff] <= op_word_ff[7:0];
    end
    if (fl_prog)
    begin
      for (int k = 0; k < nvs_pkg::BLOCK_WORDS; k++)
      begin
        fl_mem[(op_idx_ff & nvs_pkg::BLOCK_MASK) | 11'(k)] <= commit_word[k];
      end
    end
    if (fl_erase)
    begin
      for (int k = 0; k < nvs_pkg::ROW_WORDS; k++)
      begin
        fl_mem[(op_idx_ff & nvs_pkg::ROW_MASK) | 11'(k)] <= nvs_pkg::ERASED_WORD;
      end
    end
  end

  // Last slot of a block is the captured data pair; the others come from the buffer
  for (genvar g = 0; g < nvs_pkg::BLOCK_WORDS; g++)
  begin : g_commit
    if (g == nvs_pkg::BLOCK_WORDS - 1)
    begin : g_last
      assign commit_word[g] = op_word_ff;
    end
    else
    begin : g_held
      assign commit_word[g] = blk_ff[g];
    end
  end

  assign rdata_out = rdata_ff;
  assign irq_req_out = flag_ff & ien_ff;
  assign write_busy_out = busy;
  assign charge_pump_on_out = pump_ff;

endmodule // nvs_access

/* File: nvs_pkg.sv */
// Shared constants and types for the nonvolatile self-access controller
package nvs_pkg;

  // Register map (byte addresses on the plain register port)
  localparam int ADDR_W = 9;
  localparam logic [8:0] OFF_IRQ_FLAGS = 9'h00D;
  localparam logic [8:0] OFF_IRQ_EN = 9'h08D;
  localparam logic [8:0] OFF_DATA_LO = 9'h10C;
  localparam logic [8:0] OFF_ADDR_LO = 9'h10D;
  localparam logic [8:0] OFF_DATA_HI = 9'h10E;
  localparam logic [8:0] OFF_ADDR_HI = 9'h10F;
  localparam logic [8:0] OFF_CTL = 9'h18C;
  localparam logic [8:0] OFF_UNLOCK = 9'h18D;

  // Field positions
  localparam int IRQ_BIT = 4;
  localparam int CTL_PGM = 7;
  localparam int CTL_FREE = 4;
  localparam int CTL_ERR = 3;
  localparam int CTL_WRITE_PERMIT = 2;
  localparam int CTL_WR = 1;
  localparam int CTL_RD = 0;

  // Widths of the data and address pairs
  localparam int DHI_W = 6;
  localparam int AHI_W = 5;
  localparam int WORD_W = 14;
  localparam int FL_IDX_W = 11;

  // Array sizes
  localparam int EE_DEPTH = 256;
  localparam int FL_DEPTH = 2048;
  localparam int ROW_WORDS = 32;
  localparam int BLOCK_WORDS = 4;
  localparam logic [1:0] LAST_IN_BLOCK = 2'h3;
  localparam logic [10:0] FL_MASK_LARGE = 11'h7FF;
  localparam logic [10:0] FL_MASK_SMALL = 11'h3FF;
  localparam logic [10:0] ROW_MASK = 11'h7E0;
  localparam logic [10:0] BLOCK_MASK = 11'h7FC;
  localparam logic [7:0] EE_SMALL_TOP = 8'h7F;
  localparam logic [13:0] ERASED_WORD = 14'h3FFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Write timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int WRITE_TIME_NS = 2000000;
  localparam int WRITE_CYCLES_DFLT = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 17;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WRITE = 3'h2,
    ST_SPARE = 3'h4
  } nvs_state_t;

  // Control register bits as stored
  typedef struct packed {
    logic pgm;
    logic free;
    logic err;
    logic write_permit;
    logic wr;
    logic rd;
  } nvs_ctl_t;

endpackage

/* File: nvs_access_chk.sv */
// Assertion checker for the nonvolatile self-access controller
`timescale 1ns/1ns
module nvs_access_chk #(
  parameter bit LARGE = 1'b1,
  parameter int WRITE_CYCLES = 8
) (
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic [nvs_pkg::ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_stb_in,
  input wire logic rd_stb_in,
  input wire logic [7:0] rdata_out,
  input wire logic pin_reset_in,
  input wire logic wdt_reset_in,
  input wire logic irq_req_out,
  input wire logic write_busy_out,
  input wire logic charge_pump_on_out
);
  logic [16:0] busy_cnt_ff;
  logic warm;
  assign warm = pin_reset_in | wdt_reset_in;
  // Counts busy cycles so the timed length can be checked at the falling edge
  always_ff @(posedge mclk_in or negedge arst_n_in)
    if (!arst_n_in)
      busy_cnt_ff <= 17'h00000;
    else
      busy_cnt_ff <= write_busy_out ? busy_cnt_ff + 17'h00001 : 17'h00000;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);
  chk_flag_layout: assert property (
    $past(rd_stb_in) && $past(addr_in) == nvs_pkg::OFF_IRQ_FLAGS |-> (rdata_out & 8'hEF) == 8'h00)
    else $error("flag register shows stray bits");
  chk_enable_layout: assert property (
    $past(rd_stb_in) && $past(addr_in) == nvs_pkg::OFF_IRQ_EN |-> (rdata_out & 8'hEF) == 8'h00)
    else $error("enable register shows stray bits");
  chk_unlock_zero: assert property (
    $past(rd_stb_in) && $past(addr_in) == nvs_pkg::OFF_UNLOCK |-> rdata_out == 8'h00)
    else $error("unlock port read nonzero");
  chk_busy_length: assert property (
    $fell(write_busy_out) && !$past(warm) |-> busy_cnt_ff == WRITE_CYCLES)
    else $error("timed write length wrong");
  chk_pump_in_write: assert property (
    charge_pump_on_out |-> write_busy_out)
    else $error("charge pump on outside a write");
  chk_warm_abort: assert property (
    warm |=> !write_busy_out && !irq_req_out)
    else $error("warm reset did not abort");
  chk_irq_hold: assert property (
    !$past(wr_stb_in) && !$past(write_busy_out) && !$past(warm) |-> $stable(irq_req_out))
    else $error("interrupt request changed without cause");
  chk_irq_cause: assert property (
    $rose(irq_req_out) |-> $past(write_busy_out) || $past(wr_stb_in))
    else $error("interrupt request rose without cause");
endmodule // nvs_access_chk
bind nvs_access nvs_access_chk #(.LARGE(LARGE), .WRITE_CYCLES(WRITE_CYCLES)) i_nvs_access_chk (
  .mclk_in(mclk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_stb_in(wr_stb_in), .rd_stb_in(rd_stb_in), .rdata_out(rdata_out),
  .pin_reset_in(pin_reset_in), .wdt_reset_in(wdt_reset_in), .irq_req_out(irq_req_out),
  .write_busy_out(write_busy_out), .charge_pump_on_out(charge_pump_on_out));

/* File: nvs_access_tb.sv */
// Self-checking bench for the nonvolatile self-access controller
`timescale 1ns/1ns
module nvs_access_tb;
  localparam logic [8:0] A_FLG = nvs_pkg::OFF_IRQ_FLAGS;
  localparam logic [8:0] A_EN = nvs_pkg::OFF_IRQ_EN;
  localparam logic [8:0] A_DL = nvs_pkg::OFF_DATA_LO;
  localparam logic [8:0] A_DH = nvs_pkg::OFF_DATA_HI;
  localparam logic [8:0] A_AL = nvs_pkg::OFF_ADDR_LO;
  localparam logic [8:0] A_AH = nvs_pkg::OFF_ADDR_HI;
  localparam logic [8:0] A_CTL = nvs_pkg::OFF_CTL;
  localparam logic [8:0] A_UL = nvs_pkg::OFF_UNLOCK;
  logic mclk_in, arst_n_in, wr_stb_in, rd_stb_in, pin_reset_in, wdt_reset_in;
  logic [8:0] addr_in;
  logic [7:0] wdata_in, rdata_out;
  logic irq_req_out, write_busy_out, charge_pump_on_out;
  int miscompares, cmp_count;
  // Short write time keeps the run brief
  nvs_access #(.LARGE(1'b1), .WRITE_CYCLES(8)) i_nvs_access (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_stb_in(wr_stb_in), .rd_stb_in(rd_stb_in), .rdata_out(rdata_out),
    .pin_reset_in(pin_reset_in), .wdt_reset_in(wdt_reset_in), .irq_req_out(irq_req_out),
    .write_busy_out(write_busy_out), .charge_pump_on_out(charge_pump_on_out));
  initial
  begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic w(input logic [8:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    wr_stb_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_stb_in <= 1'b0;
  endtask
  task automatic r(input logic [8:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    rd_stb_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_stb_in <= 1'b0;
    #1;
    chk(rdata_out, e);
  endtask
  task automatic idle();
    int n;
    n = 0;
    repeat (3) @(posedge mclk_in);
    while (write_busy_out !== 1'b0 && n < 40)
    begin
      @(posedge mclk_in);
      n++;
    end
    #1;
    chk({7'h00, write_busy_out}, 8'h00);
  endtask
  task automatic conclude();
    if (miscompares == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    #200000;
    miscompares++;
    conclude();
  end
  initial
  begin
    arst_n_in = 1'b0;
    wr_stb_in = 1'b0;
    rd_stb_in = 1'b0;
    pin_reset_in = 1'b0;
    wdt_reset_in = 1'b0;
    addr_in = 9'h000;
    wdata_in = 8'h00;
    miscompares = 0;
    cmp_count = 0;
    repeat (6) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    r(A_FLG, 8'h00);
    r(A_EN, 8'h00);
    r(A_CTL, 8'h00);
    r(9'h000, 8'h00);
    w(A_UL, 8'hFF);
    r(A_UL, 8'h00);
    w(A_EN, 8'hFF);
    r(A_EN, 8'h10);
    w(A_EN, 8'h00);
    w(A_FLG, 8'hFF);
    r(A_FLG, 8'h10);
    w(A_FLG, 8'h00);
    w(A_CTL, 8'h02);
    r(A_CTL, 8'h00);
    w(A_AL, 8'hA5);
    w(A_DL, 8'h3C);
    w(A_CTL, 8'h04);
    w(A_CTL, 8'h06);
    r(A_CTL, 8'h06);
    chk({6'h00, charge_pump_on_out, write_busy_out}, 8'h03);
    w(A_CTL, 8'h04);
    r(A_CTL, 8'h06);
    idle();
    r(A_FLG, 8'h10);
    chk({7'h00, irq_req_out}, 8'h00);
    r(A_CTL, 8'h04);
    w(A_EN, 8'h10);
    #1;
    chk({7'h00, irq_req_out}, 8'h01);
    w(A_FLG, 8'h00);
    #1;
    chk({7'h00, irq_req_out}, 8'h00);
    w(A_DL, 8'h00);
    w(A_CTL, 8'h01);
    r(A_CTL, 8'h00);
    r(A_DL, 8'h3C);
    w(A_AH, 8'hFF);
    r(A_AH, 8'h1F);
    w(A_AH, 8'h01);
    w(A_AL, 8'h20);
    w(A_CTL, 8'h94);
    w(A_CTL, 8'h96);
    idle();
    chk({7'h00, irq_req_out}, 8'h01);
    w(A_CTL, 8'h81);
    r(A_DL, 8'hFF);
    r(A_DH, 8'h3F);
    w(A_CTL, 8'h84);
    w(A_DH, 8'h2A);
    for (int i = 0; i < 4; i++)
    begin
      w(A_AL, 8'h20 + i[7:0]);
      w(A_DL, 8'h50 + i[7:0]);
      w(A_CTL, 8'h86);
      idle();
    end
    w(A_AH, 8'h09);
    for (int i = 0; i < 4; i++)
    begin
      w(A_AL, 8'h20 + i[7:0]);
      w(A_CTL, 8'h81);
      r(A_DL, 8'h50 + i[7:0]);
      r(A_DH, 8'h2A);
    end
    for (int j = 0; j < 2; j++)
    begin
      w(A_CTL, 8'h94);
      w(A_CTL, 8'h96);
      repeat (3) @(posedge mclk_in);
      pin_reset_in <= (j == 0);
      wdt_reset_in <= (j == 1);
      @(posedge mclk_in);
      pin_reset_in <= 1'b0;
      wdt_reset_in <= 1'b0;
      r(A_CTL, 8'h08);
      r(A_AH, 8'h09);
      r(A_AL, 8'h23);
      w(A_CTL, 8'h00);
    end
    w(A_FLG, 8'h00);
    w(A_EN, 8'h10);
    #1;
    chk({7'h00, irq_req_out}, 8'h00);
    conclude();
  end
endmodule // nvs_access_tb
